// *** ocr_cfg.svh ***
// constants for the on-chip ram decode and enable block
`ifndef OCR_CFG_SVH
`define OCR_CFG_SVH
`define OCR_SYSCTL_OFS      16'hFF39
`define OCR_SYSCTL_RST      8'h01
`define OCR_MEM_EN_BIT      0
`define OCR_ADV_8K_LO       24'hFFDC00
`define OCR_ADV_4K_LO       24'hFFEC00
`define OCR_ADV_HI          24'hFFFBFF
`define OCR_NRM_8K_LO       16'hE400
`define OCR_NRM_4K_LO       16'hEC00
`define OCR_NRM_HI          16'hFBFF
`define OCR_WORDS           4096
`define OCR_AW              12
`define OCR_AV_SYSCTL       4'h0
`define OCR_AV_STATUS       4'h1
`endif

// *** ocr_chk_asserts.sv ***
// assertion checker for the on-chip ram block
`timescale 1ns/1ps
module ocr_chk (
    input logic        clk_sys,
    input logic        sys_rst,
    input logic        advanced_mode,
    input logic        large_variant,
    input logic        cpu_req,
    input logic [23:0] cpu_addr,
    input logic        cpu_ack,
    input logic        cpu_hit,
    input logic        offchip_sel,
    input logic        avs_read,
    input logic        avs_waitrequest
);
    wire logic [1:0] m = {advanced_mode, large_variant};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_hit_ack: assert property (cpu_req && cpu_hit |=> cpu_ack)
        else $error("hit without ack");
    a_miss_off: assert property (cpu_req && !cpu_hit |-> offchip_sel ##1 !cpu_ack)
        else $error("miss not off-chip");
    a_off_only: assert property (offchip_sel |-> cpu_req && !cpu_hit)
        else $error("stray off-chip select");
    a_win_adv8: assert property (cpu_hit && m == 2'h3 |-> cpu_addr inside {[24'hFFDC00:24'hFFFBFF]})
        else $error("bad window");
    a_win_adv4: assert property (cpu_hit && m == 2'h2 |-> cpu_addr inside {[24'hFFEC00:24'hFFFBFF]})
        else $error("bad window");
    a_win_nrm8: assert property (cpu_hit && m == 2'h1 |-> cpu_addr inside {[24'h00E400:24'h00FBFF]})
        else $error("bad window");
    a_win_nrm4: assert property (cpu_hit && m == 2'h0 |-> cpu_addr inside {[24'h00EC00:24'h00FBFF]})
        else $error("bad window");
    a_wait_one: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    cover property (cpu_ack);
    cover property (offchip_sel);
    cover property (avs_read && !avs_waitrequest);
endmodule
bind ocr_top ocr_chk u_chk (.*);

// *** ocr_cpu.sv ***
// processor-side access model for the on-chip ram block
`timescale 1ns/1ps
module ocr_cpu (
    input  logic        clk_sys,
    output logic        cpu_req,
    output logic        cpu_write,
    output logic        cpu_word,
    output logic [23:0] cpu_addr,
    output logic [15:0] cpu_wdata
);
    initial {cpu_req, cpu_write, cpu_word, cpu_addr, cpu_wdata} = 43'h0;
    task acc(input logic w, input logic wd, input logic [23:0] ad, input logic [15:0] dt);
        cpu_req <= 1'b1;
        cpu_write <= w;
        cpu_word <= wd;
        cpu_addr <= wd ? {ad[23:1], 1'b0} : ad;
        cpu_wdata <= dt;
        @(posedge clk_sys);
        cpu_req <= 1'b0;
        cpu_wdata <= ~dt;
    endtask
endmodule

// *** ocr_decode.sv ***
// address window decode for the on-chip ram
`timescale 1ns/1ps
`include "ocr_cfg.svh"
module ocr_decode (
    input  wire logic        mem_enable,
    input  wire logic        advanced_mode,
    input  wire logic        large_variant,
    input  wire logic [23:0] addr,
    output logic             hit,
    output logic [11:0]      word_index
);
    logic [23:0] lo;
    logic [23:0] hi;
    logic [23:0] ofs;
    always_comb begin
        if (advanced_mode) begin
            lo = large_variant ? `OCR_ADV_8K_LO : `OCR_ADV_4K_LO;
            hi = `OCR_ADV_HI;
        end else begin
            lo = {8'h00, large_variant ? `OCR_NRM_8K_LO : `OCR_NRM_4K_LO};
            hi = {8'h00, `OCR_NRM_HI};
        end
        hit = mem_enable && (addr >= lo) && (addr <= hi);
        ofs = addr - (advanced_mode ? `OCR_ADV_8K_LO : {8'h00, `OCR_NRM_8K_LO});
        if (!large_variant) begin
            ofs = addr - lo;
        end
        word_index = ofs[12:1];
    end
endmodule

// *** ocr_pkg.sv ***
// types for the on-chip ram decode and enable block
package ocr_pkg;
    typedef enum logic [1:0] {
        OCR_IDLE,
        OCR_ACK
    } ocr_avs_t;
    typedef struct packed {
        logic [7:0]  sysctl;
        ocr_avs_t    avs;
        logic [31:0] rdata;
        logic [15:0] cpu_rdata;
        logic        cpu_ack;
    } ocr_state_t;
endpackage

// *** ocr_top.sv ***
// on-chip static ram with window decode, enable control and avalon register slave
// ==========================================
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`include "ocr_cfg.svh"
module ocr_top (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        advanced_mode,
    input  wire logic        large_variant,
    input  wire logic        soft_standby,
    input  wire logic        cpu_req,
    input  wire logic        cpu_write,
    input  wire logic        cpu_word,
    input  wire logic [23:0] cpu_addr,
    input  wire logic [15:0] cpu_wdata,
    output logic [15:0]      cpu_rdata,
    output logic             cpu_ack,
    output logic             cpu_hit,
    output logic             offchip_sel,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);
    // ==========================================
    // state and storage
    ocr_pkg::ocr_state_t st_ff;
    ocr_pkg::ocr_state_t nxt_st;
    logic [7:0]  ram_hi [0:`OCR_WORDS-1];
    logic [7:0]  ram_lo [0:`OCR_WORDS-1];
    logic        hit;
    logic [11:0] widx;
    logic        wr_hi;
    logic        wr_lo;

    ocr_decode u_dec (
        .mem_enable    (st_ff.sysctl[`OCR_MEM_EN_BIT]),
        .advanced_mode (advanced_mode),
        .large_variant (large_variant),
        .addr          (cpu_addr),
        .hit           (hit),
        .word_index    (widx)
    );

    // ==========================================
    // lane selection
    always_comb begin
        wr_hi = cpu_req && hit && cpu_write && (cpu_word || !cpu_addr[0]);
        wr_lo = cpu_req && hit && cpu_write && (cpu_word || cpu_addr[0]);
    end

    always_ff @(posedge clk_sys) begin
        if (wr_hi) begin
            ram_hi[widx] <= cpu_word ? cpu_wdata[15:8] : cpu_wdata[15:8];
        end
        if (wr_lo) begin
            ram_lo[widx] <= cpu_word ? cpu_wdata[7:0] : cpu_wdata[7:0];
        end
    end

    // ==========================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cpu_ack = cpu_req && hit;
        if (cpu_req && hit && !cpu_write) begin
            nxt_st.cpu_rdata = {ram_hi[widx], ram_lo[widx]};
        end
        case (st_ff.avs)
            ocr_pkg::OCR_IDLE: begin
                if (avs_write) begin
                    nxt_st.avs = ocr_pkg::OCR_ACK;
                end else if (avs_read) begin
                    case (avs_address)
                        `OCR_AV_SYSCTL: nxt_st.rdata = {24'h000000, st_ff.sysctl};
                        `OCR_AV_STATUS: nxt_st.rdata = {29'h00000000, large_variant,
                                                        advanced_mode, hit};
                        default:        nxt_st.rdata = 32'h00000000;
                    endcase
                    nxt_st.avs = ocr_pkg::OCR_ACK;
                end
            end
            ocr_pkg::OCR_ACK: begin
                // write lands at the edge where waitrequest is seen low
                if (avs_write && avs_address == `OCR_AV_SYSCTL &&
                    avs_byteenable[0] && !soft_standby) begin
                    nxt_st.sysctl = avs_writedata[7:0];
                end
                nxt_st.avs = ocr_pkg::OCR_IDLE;
            end
            default: begin
                nxt_st.avs = ocr_pkg::OCR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_ff.sysctl    <= `OCR_SYSCTL_RST;
            st_ff.avs       <= ocr_pkg::OCR_IDLE;
            st_ff.rdata     <= 32'h00000000;
            st_ff.cpu_rdata <= 16'h0000;
            st_ff.cpu_ack   <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================
    // outputs
    always_comb begin
        cpu_rdata       = st_ff.cpu_rdata;
        cpu_ack         = st_ff.cpu_ack;
        cpu_hit         = hit;
        offchip_sel     = cpu_req && !hit;
        avs_readdata    = st_ff.rdata;
        avs_waitrequest = (avs_read || avs_write) && (st_ff.avs != ocr_pkg::OCR_ACK);
    end
endmodule

// *** test_onchip_ram_decode_enable.sv ***
// self-checking bench for the on-chip ram block
`timescale 1ns/1ps
module test_onchip_ram_decode_enable;
    logic        clk_sys, sys_rst, advanced_mode, large_variant, soft_standby;
    logic        cpu_req, cpu_write, cpu_word, cpu_ack, cpu_hit, offchip_sel;
    logic [23:0] cpu_addr, a;
    logic [15:0] cpu_wdata, cpu_rdata, d, rd_s;
    logic        ack_s, hit_s, off_s;
    logic [3:0]  avs_address;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, r;
    int          errors, check_count;
    ocr_top uut (.*);
    ocr_cpu cpu (.*);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [23:0] wlo(input logic [1:0] m);
        return m[1] ? (m[0] ? 24'hFFDC00 : 24'hFFEC00) : (m[0] ? 24'h00E400 : 24'h00EC00);
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("Error %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task av(input logic w, input logic [3:0] ad, input logic [31:0] wd);
        avs_address <= ad;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= wd;
        @(posedge clk_sys);
        while (avs_waitrequest) @(posedge clk_sys);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task cyc(input logic w, input logic wd, input logic [23:0] ad, input logic [15:0] dt);
        fork
            cpu.acc(w, wd, ad, dt);
            begin
                @(negedge clk_sys);
                hit_s = cpu_hit;
                off_s = offchip_sel;
            end
        join
        @(negedge clk_sys);
        ack_s = cpu_ack;
        rd_s = cpu_rdata;
        @(posedge clk_sys);
    endtask
    task give_verdict;
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        void'($urandom(28964));
        {sys_rst, soft_standby, avs_read, avs_write, advanced_mode, large_variant} = 6'h20;
        {avs_address, avs_writedata} = 36'h0;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        av(1'b0, 4'h0, 32'h0);
        chk(r[7:0], 8'h01);
        for (int m = 0; m < 4; m++) begin
            {advanced_mode, large_variant} <= 2'(m);
            a = wlo(2'(m)) + 24'($urandom % 4096) & 24'hFFFFFE;
            d = 16'($urandom);
            cyc(1'b1, 1'b1, a, d);
            chk(ack_s, 1'b1);
            chk(hit_s, 1'b1);
            cyc(1'b0, 1'b0, a, 16'h0);
            chk(rd_s[15:8], d[15:8]);
            cyc(1'b0, 1'b0, a | 24'h1, 16'h0);
            chk(rd_s[7:0], d[7:0]);
            cyc(1'b0, 1'b0, wlo(2'(m)) - 24'h1, 16'h0);
            chk(ack_s, 1'b0);
            chk(off_s, 1'b1);
        end
        av(1'b1, 4'h0, 32'h0);
        cyc(1'b0, 1'b1, a, 16'h0);
        chk(ack_s, 1'b0);
        chk(off_s, 1'b1);
        soft_standby <= 1'b1;
        av(1'b1, 4'h0, 32'h1);
        av(1'b0, 4'h0, 32'h0);
        chk(r[0], 1'b0);
        give_verdict;
    end
    initial begin
        #100000;
        errors++;
        give_verdict;
    end
endmodule
